// ### vrs_regulator_regs.sv
// Dual-rail serial VID register bank, voltage ramping and command handling
`timescale 1ns/1ps
`default_nettype none
module vrs_regulator_regs #(
  parameter int RAILS = 2
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Serial voltage-ID bus
  input  wire logic                   sclk,
  input  wire logic                   sdio_in,
  output logic                        sdio_out,
  output logic                        sdio_oe,
  output logic                        alert_n,
  // Pins and straps
  input  wire logic                   ctrl_enable,
  input  wire logic [2:0]             boot_strap_sel,
  input  wire logic [RAILS-1:0][7:0]  current_limit_strap_pin,
  // Telemetry from converter logic
  input  wire logic [RAILS-1:0][7:0]  vout_adc,
  input  wire logic [RAILS-1:0][7:0]  iout_adc,
  input  wire logic [RAILS-1:0][7:0]  temp_adc,
  input  wire logic [RAILS-1:0][7:0]  status1_in,
  input  wire logic [RAILS-1:0][7:0]  status2_in,
  // Regulation outputs
  output logic [RAILS-1:0][7:0]       dac_vid,
  output logic [RAILS-1:0][7:0]       power_state,
  output logic [RAILS-1:0]            regulator_hot_flag
);
  // The register map and rail decoding serve exactly two rails
  if (RAILS != 2) begin : g_rails_check
    $error("RAILS must be 2");
  end

  vrs_link_if lk ();

  vrs_serial_link u_link (
    .sclk     (sclk),
    .rst      (rst),
    .sdio_in  (sdio_in),
    .sdio_out (sdio_out),
    .sdio_oe  (sdio_oe),
    .lk       (lk.link)
  );

  function automatic logic is_mapped(input logic [7:0] a);
    unique case (a)
      vrs_pkg::REG_STAT1, vrs_pkg::REG_STAT2, vrs_pkg::REG_IOUT,
      vrs_pkg::REG_VOUT, vrs_pkg::REG_TEMP, vrs_pkg::REG_POWER,
      vrs_pkg::REG_LAST2, vrs_pkg::REG_CURLIM, vrs_pkg::REG_HOTLIM,
      vrs_pkg::REG_FAST, vrs_pkg::REG_SLOW, vrs_pkg::REG_BOOT,
      vrs_pkg::REG_MAXVID, vrs_pkg::REG_TARGET, vrs_pkg::REG_PSTATE,
      vrs_pkg::REG_OFFSET, vrs_pkg::REG_MULTI: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic is_writable(input logic [7:0] a);
    unique case (a)
      vrs_pkg::REG_HOTLIM, vrs_pkg::REG_MAXVID, vrs_pkg::REG_TARGET,
      vrs_pkg::REG_PSTATE, vrs_pkg::REG_OFFSET, vrs_pkg::REG_MULTI: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_writable

  function automatic logic is_setvid(input logic [7:0] c);
    return c == vrs_pkg::CMD_FAST || c == vrs_pkg::CMD_SLOW || c == vrs_pkg::CMD_DECAY;
  endfunction : is_setvid

  // Pin synchronisers
  logic                  en_s1, en_s2, en_s3;
  logic [2:0]            boot_s1, boot_s2;
  logic [RAILS-1:0][7:0] cur_s1, cur_s2;
  logic                  en_rise;

  always_ff @(posedge clk) begin
    en_s1   <= ctrl_enable;
    en_s2   <= en_s1;
    en_s3   <= en_s2;
    boot_s1 <= boot_strap_sel;
    boot_s2 <= boot_s1;
    cur_s1  <= current_limit_strap_pin;
    cur_s2  <= cur_s1;
  end
  assign en_rise = en_s2 & ~en_s3;

  // Request arrival from the link domain
  logic req_s1, req_s2, req_s3;
  logic req_pulse;
  // Cleared in reset so a link toggle reset cannot pose as a fresh request
  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= lk.req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end
  assign req_pulse = req_s2 ^ req_s3;

  // Per-rail state, then the shared boot code and capture flag
  logic [7:0]         tgt_r    [RAILS];
  logic [7:0]         ps_r     [RAILS];
  logic [7:0]         off_r    [RAILS];
  logic [7:0]         maxv_r   [RAILS];
  logic [7:0]         hotl_r   [RAILS];
  logic [7:0]         multi_r  [RAILS];
  logic [7:0]         last2_r  [RAILS];
  logic [7:0]         curlim_r [RAILS];
  logic [7:0]         pwr_r    [RAILS];
  logic [7:0]         dac_r    [RAILS];
  logic [7:0]         eff      [RAILS];
  logic [15:0]        acc_r    [RAILS];
  vrs_pkg::vrs_slew_e mode_r   [RAILS];
  logic [7:0]         boot_r;
  logic               capt_r;

  genvar i;
  generate
    for (i = 0; i < RAILS; i++) begin : g_rail
      logic              hit;
      logic signed [9:0] sum;
      logic [15:0]       inc;
      logic [15:0]       acc_nxt;
      logic [15:0]       prod;

      assign hit = req_pulse && lk.rail == 1'(i);

      always_ff @(posedge clk) begin
        if (rst) begin
          tgt_r[i]    <= vrs_pkg::RST_ZERO;
          ps_r[i]     <= vrs_pkg::RST_ZERO;
          off_r[i]    <= vrs_pkg::RST_ZERO;
          maxv_r[i]   <= vrs_pkg::RST_MAXVID;
          hotl_r[i]   <= vrs_pkg::RST_HOTLIM;
          multi_r[i]  <= vrs_pkg::RST_ZERO;
          last2_r[i]  <= vrs_pkg::RST_ZERO;
          curlim_r[i] <= vrs_pkg::RST_ZERO;
          mode_r[i]   <= vrs_pkg::VRS_SLEW_FAST;
        end else if (en_rise) begin
          tgt_r[i]  <= vrs_pkg::boot_vid(boot_s2);
          mode_r[i] <= vrs_pkg::VRS_SLEW_FAST;
          if (!capt_r) curlim_r[i] <= cur_s2[i];
        end else if (hit) begin
          if (is_setvid(lk.cmd) && lk.payload <= maxv_r[i]) begin
            tgt_r[i] <= lk.payload;
            unique case (lk.cmd)
              vrs_pkg::CMD_FAST: mode_r[i] <= vrs_pkg::VRS_SLEW_FAST;
              vrs_pkg::CMD_SLOW: mode_r[i] <= vrs_pkg::VRS_SLEW_SLOW;
              default:           mode_r[i] <= vrs_pkg::VRS_SLEW_DECAY;
            endcase
          end
          if (lk.cmd == vrs_pkg::CMD_GET && lk.payload == vrs_pkg::REG_STAT2)
            last2_r[i] <= status2_in[i];
          if (lk.cmd == vrs_pkg::CMD_SET && is_writable(lk.payload)) begin
            unique case (lk.payload)
              vrs_pkg::REG_HOTLIM: hotl_r[i]  <= lk.wdata;
              vrs_pkg::REG_MAXVID: maxv_r[i]  <= lk.wdata;
              vrs_pkg::REG_TARGET: tgt_r[i]   <= lk.wdata;
              vrs_pkg::REG_PSTATE: ps_r[i]    <= lk.wdata;
              vrs_pkg::REG_OFFSET: off_r[i]   <= lk.wdata;
              default:             multi_r[i] <= lk.wdata;
            endcase
          end
        end
      end

      // Effective target with signed margin, clamped to the code range
      assign sum = $signed({2'b00, tgt_r[i]}) + $signed({{2{off_r[i][7]}}, off_r[i]});
      always_comb begin
        if (sum < 0)
          eff[i] = vrs_pkg::RST_ZERO;
        else if (sum > $signed({2'b00, vrs_pkg::VID_TOP}))
          eff[i] = vrs_pkg::VID_TOP;
        else
          eff[i] = sum[7:0];
      end

      // Slew pacing: accumulate uV per clock, step one code per VID step
      assign inc = (mode_r[i] == vrs_pkg::VRS_SLEW_SLOW)
                   ? 16'(vrs_pkg::SLOW_RATE) * vrs_pkg::PERIOD_NS
                   : 16'(vrs_pkg::FAST_RATE) * vrs_pkg::PERIOD_NS;
      assign acc_nxt = acc_r[i] + inc;

      always_ff @(posedge clk) begin
        if (rst || !en_s2) begin
          dac_r[i] <= vrs_pkg::RST_ZERO;
          acc_r[i] <= '0;
        end else if (mode_r[i] == vrs_pkg::VRS_SLEW_DECAY && eff[i] < dac_r[i]) begin
          dac_r[i] <= eff[i];
          acc_r[i] <= '0;
        end else if (eff[i] == dac_r[i]) begin
          acc_r[i] <= '0;
        end else if (acc_nxt >= vrs_pkg::STEP_UV) begin
          acc_r[i] <= acc_nxt - vrs_pkg::STEP_UV;
          if (eff[i] > dac_r[i]) dac_r[i] <= dac_r[i] + 8'h01;
          else dac_r[i] <= dac_r[i] - 8'h01;
        end else begin
          acc_r[i] <= acc_nxt;
        end
      end

      // Telemetry derived values
      assign prod = 16'(vout_adc[i]) * 16'(iout_adc[i]);
      always_ff @(posedge clk) begin
        if (rst) begin
          pwr_r[i]              <= vrs_pkg::RST_POWER;
          regulator_hot_flag[i] <= 1'b0;
        end else begin
          // Zero is reserved for unsupported, so a tiny product reads as one
          pwr_r[i] <= (prod[15:8] == 8'h00) ? vrs_pkg::RST_POWER : prod[15:8];
          regulator_hot_flag[i] <= temp_adc[i] >= hotl_r[i];
        end
      end

      assign dac_vid[i]     = dac_r[i];
      assign power_state[i] = ps_r[i];
    end
  endgenerate

  // Read multiplexer for the addressed rail
  // Requests carry the rail, so one mux serves both register sets
  logic [7:0] rd_val;
  logic       r;
  assign r = lk.rail;
  always_comb begin
    unique case (lk.payload)
      vrs_pkg::REG_STAT1:  rd_val = status1_in[r];
      vrs_pkg::REG_STAT2:  rd_val = status2_in[r];
      vrs_pkg::REG_IOUT:   rd_val = iout_adc[r];
      vrs_pkg::REG_VOUT:   rd_val = vout_adc[r];
      vrs_pkg::REG_TEMP:   rd_val = temp_adc[r];
      vrs_pkg::REG_POWER:  rd_val = pwr_r[r];
      vrs_pkg::REG_LAST2:  rd_val = last2_r[r];
      vrs_pkg::REG_CURLIM: rd_val = curlim_r[r];
      vrs_pkg::REG_HOTLIM: rd_val = hotl_r[r];
      vrs_pkg::REG_FAST:   rd_val = vrs_pkg::FAST_RATE;
      vrs_pkg::REG_SLOW:   rd_val = vrs_pkg::SLOW_RATE;
      vrs_pkg::REG_BOOT:   rd_val = boot_r;
      vrs_pkg::REG_MAXVID: rd_val = maxv_r[r];
      vrs_pkg::REG_TARGET: rd_val = tgt_r[r];
      vrs_pkg::REG_PSTATE: rd_val = ps_r[r];
      vrs_pkg::REG_OFFSET: rd_val = off_r[r];
      vrs_pkg::REG_MULTI:  rd_val = multi_r[r];
      default:             rd_val = vrs_pkg::RST_ZERO;
    endcase
  end

  // Response builder; toggles back to the link on the same edge that loads ack and rdata
  always_ff @(posedge clk) begin
    if (rst) begin
      lk.ack     <= vrs_pkg::VRS_ACK_OK;
      lk.rdata   <= vrs_pkg::RST_ZERO;
      lk.rsp_tgl <= 1'b0;
    end else if (req_pulse) begin
      lk.rsp_tgl <= ~lk.rsp_tgl;
      lk.rdata   <= vrs_pkg::RST_ZERO;
      if (is_setvid(lk.cmd)) begin
        lk.ack <= (lk.payload > maxv_r[r]) ? vrs_pkg::VRS_ACK_NOTSUP
                                           : vrs_pkg::VRS_ACK_OK;
      end else if (lk.cmd == vrs_pkg::CMD_GET) begin
        lk.ack   <= is_mapped(lk.payload) ? vrs_pkg::VRS_ACK_OK : vrs_pkg::VRS_ACK_REJ;
        lk.rdata <= rd_val;
      end else if (lk.cmd == vrs_pkg::CMD_SET) begin
        if (is_writable(lk.payload))
          lk.ack <= vrs_pkg::VRS_ACK_OK;
        else if (is_mapped(lk.payload))
          lk.ack <= vrs_pkg::VRS_ACK_NOTSUP;
        else
          lk.ack <= vrs_pkg::VRS_ACK_REJ;
      end else begin
        lk.ack <= vrs_pkg::VRS_ACK_REJ;
      end
    end
  end

  // Boot strap capture happens on every enable rise; capt_r marks the first one after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      capt_r <= 1'b0;
      boot_r <= vrs_pkg::RST_ZERO;
    end else if (en_rise) begin
      capt_r <= 1'b1;
      boot_r <= vrs_pkg::boot_vid(boot_s2);
    end
  end

  // Alert while either rail reports a status one condition
  always_ff @(posedge clk) begin
    if (rst) alert_n <= 1'b1;
    else alert_n <= ~(|status1_in[0] | |status1_in[1]);
  end

  // Status two read on rail zero, outside an enable rise
  logic hit0_get2;
  assign hit0_get2 = req_pulse && !lk.rail && lk.cmd == vrs_pkg::CMD_GET
                     && lk.payload == vrs_pkg::REG_STAT2 && !en_rise;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_power_floor: assert property (##1 pwr_r[0] != 8'h00)
    else $error("power register reads zero");
  a_last2_copy: assert property (hit0_get2 |=> last2_r[0] == $past(status2_in[0]))
    else $error("last-read status not copied");
  a_curlim_hold: assert property (capt_r |=> $stable(curlim_r[0]))
    else $error("current limit changed after capture");
  a_hot_flag: assert property (##1 regulator_hot_flag[0] ==
    ($past(temp_adc[0]) >= $past(hotl_r[0])))
    else $error("hot flag mismatches limit");
  a_boot_load: assert property (en_rise |=> tgt_r[0] == vrs_pkg::boot_vid($past(boot_s2)))
    else $error("boot target not loaded");
  a_maxvid_nack: assert property (req_pulse && is_setvid(lk.cmd)
    && lk.payload > maxv_r[r] && !en_rise |=> lk.ack == vrs_pkg::VRS_ACK_NOTSUP
    && $stable(tgt_r[0]) && $stable(tgt_r[1]))
    else $error("over-maximum request accepted");
  a_decay_drop: assert property (en_s2 && mode_r[0] == vrs_pkg::VRS_SLEW_DECAY
    && eff[0] < dac_r[0] |=> dac_r[0] == $past(eff[0]))
    else $error("decay did not drop at once");
  a_ramp_unit: assert property (en_s2 && $past(en_s2)
    && mode_r[0] != vrs_pkg::VRS_SLEW_DECAY && $past(mode_r[0]) != vrs_pkg::VRS_SLEW_DECAY
    |-> (dac_r[0] - $past(dac_r[0])) inside {8'h00, 8'h01, 8'hff})
    else $error("ramp moved more than one code");
  a_setvid_take: assert property (req_pulse && !lk.rail && is_setvid(lk.cmd)
    && lk.payload <= maxv_r[0] && !en_rise |=> tgt_r[0] == $past(lk.payload))
    else $error("accepted voltage request not stored");
  a_pstate_write: assert property (req_pulse && lk.rail
    && lk.cmd == vrs_pkg::CMD_SET && lk.payload == vrs_pkg::REG_PSTATE && !en_rise
    |=> ps_r[1] == $past(lk.wdata))
    else $error("power state write lost");

  c_fast_ramp: cover property (mode_r[0] == vrs_pkg::VRS_SLEW_FAST && dac_r[0] != eff[0]);
  c_decay: cover property (mode_r[0] == vrs_pkg::VRS_SLEW_DECAY && eff[0] < dac_r[0]);
  c_nack: cover property (req_pulse ##1 lk.ack == vrs_pkg::VRS_ACK_NOTSUP);
  c_slow_ramp: cover property (mode_r[0] == vrs_pkg::VRS_SLEW_SLOW && dac_r[0] != eff[0]);
  c_last2_read: cover property (hit0_get2);
endmodule : vrs_regulator_regs
`default_nettype wire

// ### vrs_pkg.sv
// Constants, codes and register map of the serial regulator register bank
`default_nettype none
package vrs_pkg;
  localparam logic [3:0] ADDR_CORE = 4'h0;
  localparam logic [3:0] ADDR_AUX  = 4'h1;
  localparam logic [7:0] CMD_FAST  = 8'h01;
  localparam logic [7:0] CMD_SLOW  = 8'h02;
  localparam logic [7:0] CMD_DECAY = 8'h03;
  localparam logic [7:0] CMD_GET   = 8'h07;
  localparam logic [7:0] CMD_SET   = 8'h08;
  typedef enum logic [1:0] {
    VRS_ACK_OK = 2'b00, VRS_ACK_NOTSUP = 2'b01, VRS_ACK_REJ = 2'b11
  } vrs_ack_e;
  typedef enum logic [1:0] {
    VRS_SLEW_FAST = 2'b00, VRS_SLEW_SLOW = 2'b01, VRS_SLEW_DECAY = 2'b10
  } vrs_slew_e;
  localparam logic [7:0] REG_STAT1  = 8'h10;
  localparam logic [7:0] REG_STAT2  = 8'h11;
  localparam logic [7:0] REG_IOUT   = 8'h15;
  localparam logic [7:0] REG_VOUT   = 8'h16;
  localparam logic [7:0] REG_TEMP   = 8'h17;
  localparam logic [7:0] REG_POWER  = 8'h18;
  localparam logic [7:0] REG_LAST2  = 8'h1c;
  localparam logic [7:0] REG_CURLIM = 8'h21;
  localparam logic [7:0] REG_HOTLIM = 8'h22;
  localparam logic [7:0] REG_FAST   = 8'h24;
  localparam logic [7:0] REG_SLOW   = 8'h25;
  localparam logic [7:0] REG_BOOT   = 8'h26;
  localparam logic [7:0] REG_MAXVID = 8'h30;
  localparam logic [7:0] REG_TARGET = 8'h31;
  localparam logic [7:0] REG_PSTATE = 8'h32;
  localparam logic [7:0] REG_OFFSET = 8'h33;
  localparam logic [7:0] REG_MULTI  = 8'h34;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_POWER  = 8'h01;
  localparam logic [7:0] RST_HOTLIM = 8'h64;
  localparam logic [7:0] RST_MAXVID = 8'hfb;
  localparam logic [7:0] FAST_RATE  = 8'h0a;
  localparam logic [7:0] SLOW_RATE  = 8'h02;
  localparam logic [7:0] VID_TOP    = 8'hff;
  // Boot VID codes in 5 mV VID encoding
  localparam logic [7:0] BOOT_0V00 = 8'h00;
  localparam logic [7:0] BOOT_0V90 = 8'h83;
  localparam logic [7:0] BOOT_1V00 = 8'h97;
  localparam logic [7:0] BOOT_1V10 = 8'hab;
  localparam logic [7:0] BOOT_1V20 = 8'hbf;
  localparam logic [7:0] BOOT_1V35 = 8'hdd;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned VID_STEP_UV   = 5000;
  localparam logic [15:0] STEP_UV = 16'(VID_STEP_UV);
  // Rate in mV/us equals uV/ns, so uV gained per clock is rate times period
  localparam logic [15:0] PERIOD_NS = 16'(CLK_PERIOD_NS);
  localparam logic [4:0] FRAME_LAST = 5'h1b;
  localparam logic [3:0] REPLY_LAST = 4'h9;

  // Strap code: 0..5 = 10k..60k, 6 = tied to ground, 7 = tied to supply
  function automatic logic [7:0] boot_vid(input logic [2:0] sel);
    logic [7:0] v;
    unique case (sel)
      3'h0:    v = BOOT_0V00;
      3'h1:    v = BOOT_0V90;
      3'h2:    v = BOOT_1V00;
      3'h3:    v = BOOT_1V10;
      3'h4:    v = BOOT_1V20;
      3'h5:    v = BOOT_1V35;
      3'h6:    v = BOOT_1V10;
      default: v = BOOT_1V35;
    endcase
    return v;
  endfunction : boot_vid
endpackage : vrs_pkg
`default_nettype wire

// ### vrs_link_if.sv
// Request and reply words crossing between the serial link and the register core
`timescale 1ns/1ps
`default_nettype none
interface vrs_link_if;
  logic       req_tgl;
  logic       rail;
  logic [7:0] cmd;
  logic [7:0] payload;
  logic [7:0] wdata;
  logic       rsp_tgl;
  logic [1:0] ack;
  logic [7:0] rdata;
  modport link (output req_tgl, rail, cmd, payload, wdata,
                input rsp_tgl, ack, rdata);
  modport core (input req_tgl, rail, cmd, payload, wdata,
                output rsp_tgl, ack, rdata);
endinterface : vrs_link_if
`default_nettype wire

// ### vrs_serial_link.sv
// Serial frame receiver and replier, clocked by the master's link clock
`timescale 1ns/1ps
`default_nettype none
module vrs_serial_link (
  // Link clock and raw reset
  input  wire logic sclk,
  input  wire logic rst,
  // Data pin
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  // Core side
  vrs_link_if.link  lk
);
  typedef enum logic [1:0] {
    VRS_L_IDLE = 2'b00, VRS_L_SHIFT = 2'b01, VRS_L_WAIT = 2'b10, VRS_L_REPLY = 2'b11
  } vrs_lstate_e;
  vrs_lstate_e state_r;
  logic        lrst_s1, lrst_r;
  logic        rsp_s1, rsp_s2, seen_r;
  logic [26:0] sr_r;
  logic [27:0] frame;
  logic [4:0]  cnt_r;
  logic [9:0]  tx_r;
  logic        is_rail;

  assign frame    = {sr_r, sdio_in};
  assign is_rail  = frame[27:24] == vrs_pkg::ADDR_CORE || frame[27:24] == vrs_pkg::ADDR_AUX;
  assign sdio_out = tx_r[9];
  assign sdio_oe  = state_r == VRS_L_REPLY;

  always_ff @(posedge sclk) begin
    lrst_s1 <= rst;
    lrst_r  <= lrst_s1;
  end

  always_ff @(posedge sclk) begin
    rsp_s1 <= lk.rsp_tgl;
    rsp_s2 <= rsp_s1;
  end

  always_ff @(posedge sclk) begin
    if (lrst_r) begin
      state_r    <= VRS_L_IDLE;
      cnt_r      <= 5'h00;
      sr_r       <= '0;
      tx_r       <= '0;
      seen_r     <= 1'b0;
      lk.req_tgl <= 1'b0;
      lk.rail    <= 1'b0;
      lk.cmd     <= vrs_pkg::RST_ZERO;
      lk.payload <= vrs_pkg::RST_ZERO;
      lk.wdata   <= vrs_pkg::RST_ZERO;
    end else begin
      unique case (state_r)
        VRS_L_IDLE: begin
          cnt_r <= 5'h00;
          if (!sdio_in) state_r <= VRS_L_SHIFT;
        end
        VRS_L_SHIFT: begin
          sr_r  <= frame[26:0];
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == vrs_pkg::FRAME_LAST) begin
            if (is_rail) begin
              lk.rail    <= frame[24];
              lk.cmd     <= frame[23:16];
              lk.payload <= frame[15:8];
              lk.wdata   <= frame[7:0];
              lk.req_tgl <= ~lk.req_tgl;
              state_r    <= VRS_L_WAIT;
            end else begin
              state_r <= VRS_L_IDLE;
            end
          end
        end
        VRS_L_WAIT: begin
          cnt_r <= 5'h00;
          if (rsp_s2 != seen_r) begin
            seen_r  <= rsp_s2;
            tx_r    <= {lk.ack, lk.rdata};
            state_r <= VRS_L_REPLY;
          end
        end
        VRS_L_REPLY: begin
          tx_r  <= {tx_r[8:0], 1'b0};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r[3:0] == vrs_pkg::REPLY_LAST) state_r <= VRS_L_IDLE;
        end
      endcase
    end
  end

  a_stray_addr: assert property (@(posedge sclk) disable iff (lrst_r)
    (state_r == VRS_L_SHIFT && cnt_r == vrs_pkg::FRAME_LAST && !is_rail)
    |=> (state_r == VRS_L_IDLE && $stable(lk.req_tgl)))
    else $error("stray address frame was not ignored");
endmodule : vrs_serial_link
`default_nettype wire

// ### vrs_master_model.sv
// Serial bus master model: frames requests and collects replies
`timescale 1ns/1ps
`default_nettype none
module vrs_master_model (
  // Link pins
  output logic      sclk,
  output var logic  sdio,
  // Device side of the data pin
  input  wire logic dev_out,
  input  wire logic dev_oe
);
  logic drv;
  // Master drives the line from drv, idling high, whenever the device does not drive it
  assign sdio = dev_oe ? dev_out : drv;
  initial begin
    sclk = 1'b0;
    drv  = 1'b1;
  end
  // Clock stands low outside frames
  task automatic tick(input int n);
    repeat (n) begin
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
  endtask : tick
  task automatic frame(input logic [27:0] req, output logic [9:0] rsp, output logic got);
    logic [28:0] bits;
    bits = {1'b0, req};
    got  = 1'b0;
    rsp  = 10'h000;
    for (int i = 28; i >= 0; i--) begin
      drv = bits[i];
      tick(1);
    end
    drv = 1'b1;
    // Keep clocking through the wait and the reply
    for (int i = 0; i < 40 && !(got && !dev_oe); i++) begin
      #16 sclk = 1'b1;
      #16;
      if (dev_oe) begin
        rsp = {rsp[8:0], dev_out};
        got = 1'b1;
      end
      sclk = 1'b0;
    end
  endtask : frame
endmodule : vrs_master_model
`default_nettype wire

// ### vrs_regulator_regs_bench.sv
// Self-checking bench for the serial regulator register bank
`timescale 1ns/1ps
`default_nettype none
module vrs_regulator_regs_bench;
  logic            clk, rst, en, sclk, sdio, d_out, d_oe, alert_n;
  logic [2:0]      sel;
  logic [1:0][7:0] cur, vo, io, tp, s1, s2, dac, pst;
  logic [1:0]      hot, ack;
  logic [7:0]      rd;
  integer          seed;
  int              fail_count, total_checks, n;
  logic [7:0] bt[8] = '{vrs_pkg::BOOT_0V00, vrs_pkg::BOOT_0V90, vrs_pkg::BOOT_1V00,
    vrs_pkg::BOOT_1V10, vrs_pkg::BOOT_1V20, vrs_pkg::BOOT_1V35, vrs_pkg::BOOT_1V10,
    vrs_pkg::BOOT_1V35};
  logic [7:0] ro[10] = '{8'h1c, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h30, 8'h31, 8'h32, 8'h33};
  logic [7:0] rv[10] = '{8'h00, 8'h00, 8'h64, 8'h0a, 8'h02, 8'h00, 8'hfb, 8'h00, 8'h00, 8'h00};
  logic [7:0] cm[3]  = '{vrs_pkg::CMD_FAST, vrs_pkg::CMD_SLOW, vrs_pkg::CMD_DECAY};
  logic [7:0] tg[3]  = '{8'hf5, 8'he5, 8'h80};
  int         lo[3]  = '{200, 760, 0};
  int         hi[3]  = '{242, 802, 2};

  vrs_master_model i_mst (.sclk(sclk), .sdio(sdio), .dev_out(d_out), .dev_oe(d_oe));
  vrs_regulator_regs i_dut (.clk(clk), .rst(rst), .sclk(sclk), .sdio_in(sdio),
    .sdio_out(d_out), .sdio_oe(d_oe), .alert_n(alert_n), .ctrl_enable(en),
    .boot_strap_sel(sel), .current_limit_strap_pin(cur), .vout_adc(vo), .iout_adc(io),
    .temp_adc(tp), .status1_in(s1), .status2_in(s2), .dac_vid(dac), .power_state(pst),
    .regulator_hot_flag(hot));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic put(input logic [3:0] a, input logic [7:0] c, p, w, input logic [1:0] e);
    logic [9:0] r;
    logic       g;
    i_mst.frame({a, c, p, w}, r, g);
    ack = g ? r[9:8] : 2'h2;
    rd  = r[7:0];
    chk("ack", {6'h00, ack}, {6'h00, e});
  endtask : put
  task automatic get(input logic [3:0] a, input logic [7:0] p, input logic [7:0] e);
    put(a, vrs_pkg::CMD_GET, p, 8'h00, 2'h0);
    chk("reg", rd, e);
  endtask : get
  task automatic wait_dac(input int r, input logic [7:0] v);
    n = 0;
    while (dac[r] !== v && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk("dac", dac[r], v);
  endtask : wait_dac
  task automatic rst_dut();
    @(posedge clk);
    rst <= 1'b1;
    en  <= 1'b0;
    fork
      repeat (3) @(posedge clk);
      i_mst.tick(4);
    join
    rst <= 1'b0;
    i_mst.tick(4);
  endtask : rst_dut
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    #3000000;
    fail_count++;
    print_verdict();
  end

  initial begin
    seed = 32'h3a6a;
    rst  = 1'b1;
    en   = 1'b0;
    sel  = 3'h0;
    {cur, vo, io, s2} = {$random(seed), $random(seed)};
    tp = 16'($random(seed)) & 16'h7f7f;
    s1 = 16'h0000;
    rst_dut();
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 10; i++) get(4'(r), ro[i], rv[i]);
      n = (int'(vo[r]) * int'(io[r])) >> 8;
      get(4'(r), 8'h18, (n == 0) ? 8'h01 : 8'(n));
    end
    $display("test reset values done");
    for (int s = 0; s < 8; s++) begin
      rst_dut();
      @(posedge clk);
      sel <= 3'(s);
      repeat (4) @(posedge clk);
      en <= 1'b1;
      wait_dac(0, bt[s]);
      get(4'h1, 8'h26, bt[s]);
    end
    get(4'h0, 8'h21, cur[0]);
    put(4'h0, vrs_pkg::CMD_SET, 8'h21, 8'h55, 2'h1);
    get(4'h0, 8'h21, cur[0]);
    chk("rail1 dac", dac[1], bt[7]);
    $display("test boot done");
    for (int k = 0; k < 3; k++) begin
      put(4'h0, cm[k], tg[k], 8'h00, 2'h0);
      wait_dac(0, tg[k]);
      chk("ramp time", 8'(n >= lo[k] && n <= hi[k]), 8'h01);
      get(4'h0, 8'h31, tg[k]);
    end
    put(4'h0, vrs_pkg::CMD_SET, 8'h30, 8'h90, 2'h0);
    put(4'h0, vrs_pkg::CMD_FAST, 8'h91, 8'h00, 2'h1);
    get(4'h0, 8'h31, 8'h80);
    put(4'h0, vrs_pkg::CMD_SET, 8'h33, 8'hff, 2'h0);
    wait_dac(0, 8'h7f);
    put(4'h0, vrs_pkg::CMD_SET, 8'h33, 8'h02, 2'h0);
    wait_dac(0, 8'h82);
    $display("test voltage commands done");
    get(4'h1, 8'h11, s2[1]);
    get(4'h1, 8'h1c, s2[1]);
    get(4'h0, 8'h11, s2[0]);
    get(4'h0, 8'h1c, s2[0]);
    get(4'h0, 8'h15, io[0]);
    get(4'h0, 8'h16, vo[0]);
    put(4'h0, 8'h05, 8'h00, 8'h00, 2'h3);
    put(4'h0, vrs_pkg::CMD_GET, 8'h40, 8'h00, 2'h3);
    put(4'h1, vrs_pkg::CMD_SET, 8'h32, 8'h5a, 2'h0);
    chk("pstate1", pst[1], 8'h5a);
    chk("pstate0", pst[0], 8'h00);
    put(4'h2, vrs_pkg::CMD_SET, 8'h22, 8'h00, 2'h2);
    get(4'h0, 8'h22, 8'h64);
    put(4'h1, vrs_pkg::CMD_SET, 8'h22, tp[1], 2'h0);
    repeat (3) @(negedge clk);
    chk("hot", {7'h00, hot[1]}, 8'h01);
    put(4'h1, vrs_pkg::CMD_SET, 8'h22, tp[1] + 8'h01, 2'h0);
    repeat (3) @(negedge clk);
    chk("hot", {7'h00, hot[1]}, 8'h00);
    chk("alert idle", {7'h00, alert_n}, 8'h01);
    @(posedge clk);
    s1[1] <= 8'h04;
    repeat (4) @(negedge clk);
    chk("alert", {7'h00, alert_n}, 8'h00);
    get(4'h1, 8'h10, 8'h04);
    $display("test misc done");
    print_verdict();
  end
endmodule : vrs_regulator_regs_bench
`default_nettype wire
